// >>> pox_defines.svh
// Offsets, field positions, reset values and constants of the outbound interrupt and
// translation block. Assumes a 12-bit APB byte address.
`ifndef POX_DEFINES_SVH
`define POX_DEFINES_SVH

`define POX_OFF_IRQ_COMMON 12'h000
`define POX_OFF_MSI_CFG0 12'h004
`define POX_OFF_MSI_CFG1 12'h008
`define POX_OFF_SYSBUS_CFG 12'h00c
`define POX_OFF_FRAME_DMA_ENGINE_CFG 12'h010
`define POX_OFF_REGION_INDEX 12'h014
`define POX_OFF_BASE_LOW 12'h018
`define POX_OFF_LIMIT 12'h01c
`define POX_OFF_HDR_CFG 12'h020
`define POX_OFF_CONTROL 12'h024
`define POX_OFF_TGT_LOW 12'h028
`define POX_OFF_TGT_HIGH 12'h02c
`define POX_OFF_STATUS 12'h030

`define POX_IRQ_GEN_EN_BIT 0
`define POX_IRQ_LEG_SEL_BIT 1

`define POX_MSI_RISE_EN_BIT 0
`define POX_MSI_FALL_EN_BIT 1
`define POX_MSI_RISE_VEC_LSB 8
`define POX_MSI_FALL_VEC_LSB 16
`define POX_MSI_TC_LSB 24

`define POX_SB_REGION_BIT 0
`define POX_SB_POISON_BIT 1
`define POX_SB_BE_LSB 4
`define POX_FD_REGION_BIT 0

`define POX_HDR_TYPE_LSB 0
`define POX_HDR_TC_LSB 5
`define POX_HDR_TD_BIT 8
`define POX_HDR_ATTR_LSB 9

`define POX_CTL_MSG_LSB 0
`define POX_CTL_ENA_BIT 31

`define POX_RST_SB_BE 4'hf
`define POX_RST_FD_BE 4'hf
`define POX_RST_LIMIT 16'h0000
`define POX_WIN_TAG 2'h3

`endif

// >>> pox_pkg.sv
// Types shared by the outbound interrupt and translation block.
// Assumes pox_defines.svh holds all numeric constants.
package pox_pkg;
  typedef enum logic [1:0] {
    POX_MSG_ASSERT_INTA,
    POX_MSG_DEASSERT_INTA,
    POX_MSG_MSI
  } pox_msg_t;

  typedef enum logic {
    POX_SRC_SYSBUS,
    POX_SRC_FRAMEDMA
  } pox_src_t;
endpackage : pox_pkg

// >>> pox_xlate.sv
// One address translation lookup: window match and offset addition.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module pox_xlate (
  input wire logic [14:0] key,
  input wire logic [29:0] low_addr,
  input wire logic [15:0] base_low,
  input wire logic [15:0] limit,
  input wire logic [31:0] tgt_high,
  input wire logic [15:0] tgt_low,
  input wire logic enable,
  output logic hit,
  output logic [63:0] pcie_addr
);
  logic [16:0] key_ext;

  assign key_ext = {2'h0, key};
  assign hit = enable && (key_ext >= {1'b0, base_low}) && (key_ext <= {1'b0, limit});
  // Offset in 64 KB steps added to the low 30 address bits
  assign pcie_addr = {34'h0, low_addr} + {tgt_high, tgt_low, 16'h0000};
endmodule : pox_xlate
`default_nettype wire

// >>> pox_outbound.sv
// Outbound side of the endpoint: interrupt messages and DMA window translation.
// Assumes APB on pclk, interrupt levels and masters synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none
`include "pox_defines.svh"
module pox_outbound import pox_pkg::*; #(
  parameter int VEC_W = 8,
  parameter int REGIONS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic msi_cap_enable,
  input wire logic endpoint_ready,
  input wire logic irq_destination_zero,
  input wire logic irq_destination_one,
  output logic msg_valid,
  output pox_msg_t msg_type,
  output logic [VEC_W-1:0] msg_vector,
  output logic [2:0] msg_tc,
  input wire logic msg_ready,
  input wire logic sb_req,
  input wire logic sb_write,
  input wire logic [31:0] sb_addr,
  output logic sb_ack,
  input wire logic fd_req,
  input wire logic fd_write,
  input wire logic [31:0] fd_addr,
  output logic fd_ack,
  output logic ob_valid,
  output logic ob_write,
  output pox_src_t ob_src,
  output logic ob_translated,
  output logic [63:0] ob_addr,
  output logic [1:0] ob_attr,
  output logic ob_td,
  output logic [2:0] ob_tc,
  output logic [4:0] ob_type,
  output logic ob_poison,
  output logic [3:0] ob_be,
  output logic [7:0] ob_msg_code,
  input wire logic ob_ready
);
  // Configuration
  logic [1:0] outbound_irq_common_config;
  logic [31:0] msi_source_config [2];
  logic sysbus_region_select;
  logic sysbus_poison_flag;
  logic [3:0] sysbus_byte_enables;
  logic framedma_region_select;
  logic xlate_region_index;
  logic [15:0] xlate_base_low [REGIONS];
  logic [15:0] xlate_limit [REGIONS];
  logic [10:0] xlate_header_config [REGIONS];
  logic [7:0] tlp_message_code [REGIONS];
  logic xlate_region_enable [REGIONS];
  logic [15:0] xlate_target_low [REGIONS];
  logic [31:0] xlate_target_high [REGIONS];

  logic outbound_irq_global_enable;
  logic legacy_line_source_select;
  assign outbound_irq_global_enable = outbound_irq_common_config[`POX_IRQ_GEN_EN_BIT];
  assign legacy_line_source_select = outbound_irq_common_config[`POX_IRQ_LEG_SEL_BIT];

  // APB slave: no wait states, access phase always completes in one cycle
  logic addr_ok;
  logic wr_en;
  logic [31:0] rd_data;
  logic [1:0] dst_level;
  logic legacy_line;

  assign dst_level = {irq_destination_one, irq_destination_zero};
  assign wr_en = pclken && psel && penable && pready && pwrite && addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0;
    case (paddr)
      `POX_OFF_IRQ_COMMON: rd_data = {30'h0, outbound_irq_common_config};
      `POX_OFF_MSI_CFG0: rd_data = msi_source_config[0];
      `POX_OFF_MSI_CFG1: rd_data = msi_source_config[1];
      `POX_OFF_SYSBUS_CFG: rd_data = {24'h0, sysbus_byte_enables, 2'h0, sysbus_poison_flag,
                                      sysbus_region_select};
      `POX_OFF_FRAME_DMA_ENGINE_CFG: rd_data = {31'h0, framedma_region_select};
      `POX_OFF_REGION_INDEX: rd_data = {31'h0, xlate_region_index};
      // Shared fields show the bank picked by the region index
      `POX_OFF_BASE_LOW: rd_data = {16'h0, xlate_base_low[xlate_region_index]};
      `POX_OFF_LIMIT: rd_data = {16'h0, xlate_limit[xlate_region_index]};
      `POX_OFF_HDR_CFG: rd_data = {21'h0, xlate_header_config[xlate_region_index]};
      `POX_OFF_CONTROL: rd_data = {xlate_region_enable[xlate_region_index], 23'h0,
                                   tlp_message_code[xlate_region_index]};
      `POX_OFF_TGT_LOW: rd_data = {16'h0, xlate_target_low[xlate_region_index]};
      `POX_OFF_TGT_HIGH: rd_data = xlate_target_high[xlate_region_index];
      `POX_OFF_STATUS: rd_data = {27'h0, endpoint_ready, msi_cap_enable, dst_level,
                                  legacy_line};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (pclken) begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rd_data;
        pslverr <= !addr_ok;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outbound_irq_common_config <= 2'h0;
      msi_source_config[0] <= 32'h0;
      msi_source_config[1] <= 32'h0;
      sysbus_region_select <= 1'b0;
      sysbus_poison_flag <= 1'b0;
      sysbus_byte_enables <= `POX_RST_SB_BE;
      framedma_region_select <= 1'b0;
      xlate_region_index <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        `POX_OFF_IRQ_COMMON: outbound_irq_common_config <= pwdata[1:0];
        `POX_OFF_MSI_CFG0: msi_source_config[0] <= {5'h0, pwdata[26:8], 6'h0, pwdata[1:0]};
        `POX_OFF_MSI_CFG1: msi_source_config[1] <= {5'h0, pwdata[26:8], 6'h0, pwdata[1:0]};
        `POX_OFF_SYSBUS_CFG: begin
          sysbus_region_select <= pwdata[`POX_SB_REGION_BIT];
          sysbus_poison_flag <= pwdata[`POX_SB_POISON_BIT];
          sysbus_byte_enables <= pwdata[`POX_SB_BE_LSB +: 4];
        end
        `POX_OFF_FRAME_DMA_ENGINE_CFG: framedma_region_select <= pwdata[`POX_FD_REGION_BIT];
        `POX_OFF_REGION_INDEX: xlate_region_index <= pwdata[0];
        default: ;
      endcase
    end
  end

  // Banked translation configuration, one bank per region
  for (genvar r = 0; r < REGIONS; r++) begin : g_bank
    logic sel;
    assign sel = wr_en && (32'(xlate_region_index) == r);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        xlate_base_low[r] <= 16'h0000;
        xlate_limit[r] <= `POX_RST_LIMIT;
        xlate_header_config[r] <= 11'h000;
        tlp_message_code[r] <= 8'h00;
        xlate_region_enable[r] <= 1'b0;
        xlate_target_low[r] <= 16'h0000;
        xlate_target_high[r] <= 32'h0;
      end else if (sel) begin
        case (paddr)
          `POX_OFF_BASE_LOW: xlate_base_low[r] <= pwdata[15:0];
          `POX_OFF_LIMIT: xlate_limit[r] <= pwdata[15:0];
          `POX_OFF_HDR_CFG: xlate_header_config[r] <= pwdata[10:0];
          `POX_OFF_CONTROL: begin
            tlp_message_code[r] <= pwdata[`POX_CTL_MSG_LSB +: 8];
            xlate_region_enable[r] <= pwdata[`POX_CTL_ENA_BIT];
          end
          `POX_OFF_TGT_LOW: xlate_target_low[r] <= pwdata[15:0];
          `POX_OFF_TGT_HIGH: xlate_target_high[r] <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Interrupt messages
  logic [1:0] dst_prev;
  logic [1:0] rise_pend;
  logic [1:0] fall_pend;
  logic [1:0] rise_evt;
  logic [1:0] fall_evt;
  logic [1:0] rise_sent;
  logic [1:0] fall_sent;
  logic legacy_want;
  logic legacy_send;
  logic msg_free;
  logic msi_active;

  // Mode follows the MSI capability enable global enable gates all
  assign msi_active = outbound_irq_global_enable && msi_cap_enable;
  assign legacy_want = outbound_irq_global_enable && !msi_cap_enable &&
                       dst_level[legacy_line_source_select];
  assign msg_free = !msg_valid || msg_ready;
  assign legacy_send = msg_free && (legacy_want != legacy_line);

  for (genvar d = 0; d < 2; d++) begin : g_dst
    // Each destination uses its own entry
    assign rise_evt[d] = msi_active && msi_source_config[d][`POX_MSI_RISE_EN_BIT] &&
                         dst_level[d] && !dst_prev[d];
    assign fall_evt[d] = msi_active && msi_source_config[d][`POX_MSI_FALL_EN_BIT] &&
                         !dst_level[d] && dst_prev[d];
    // New edges win over the clear of the same flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rise_pend[d] <= 1'b0;
        fall_pend[d] <= 1'b0;
        dst_prev[d] <= 1'b0;
      end else if (pclken) begin
        dst_prev[d] <= dst_level[d];
        rise_pend[d] <= (msi_active && rise_pend[d] && !rise_sent[d]) || rise_evt[d];
        fall_pend[d] <= (msi_active && fall_pend[d] && !fall_sent[d]) || fall_evt[d];
      end
    end
  end

  // Fixed priority: legacy, then destination zero, then one
  always_comb begin
    rise_sent = 2'b00;
    fall_sent = 2'b00;
    if (msg_free && !legacy_send) begin
      if (rise_pend[0]) rise_sent[0] = 1'b1;
      else if (fall_pend[0]) fall_sent[0] = 1'b1;
      else if (rise_pend[1]) rise_sent[1] = 1'b1;
      else if (fall_pend[1]) fall_sent[1] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_valid <= 1'b0;
      msg_type <= POX_MSG_DEASSERT_INTA;
      msg_vector <= '0;
      msg_tc <= 3'h0;
      legacy_line <= 1'b0;
    end else if (pclken && msg_free) begin
      msg_valid <= legacy_send || (|rise_sent) || (|fall_sent);
      if (legacy_send) begin
        legacy_line <= legacy_want;
        msg_type <= legacy_want ? POX_MSG_ASSERT_INTA : POX_MSG_DEASSERT_INTA;
        msg_vector <= '0;
        msg_tc <= 3'h0;
      end else if (|rise_sent) begin
        msg_type <= POX_MSG_MSI;
        msg_vector <= msi_source_config[rise_sent[1]][`POX_MSI_RISE_VEC_LSB +: VEC_W];
        msg_tc <= msi_source_config[rise_sent[1]][`POX_MSI_TC_LSB +: 3];
      end else if (|fall_sent) begin
        msg_type <= POX_MSG_MSI;
        msg_vector <= msi_source_config[fall_sent[1]][`POX_MSI_FALL_VEC_LSB +: VEC_W];
        msg_tc <= msi_source_config[fall_sent[1]][`POX_MSI_TC_LSB +: 3];
      end
    end
  end

  // Outbound translation, one lookup per source
  logic [31:0] src_addr [2];
  logic src_region [2];
  logic [1:0] src_hit;
  logic [63:0] src_pcie [2];

  assign src_addr[0] = sb_addr;
  assign src_addr[1] = fd_addr;
  assign src_region[0] = sysbus_region_select;
  assign src_region[1] = framedma_region_select;

  for (genvar s = 0; s < 2; s++) begin : g_src
    // Region select forms the top key bit, so the two regions land in distinct key ranges
    pox_xlate u_xlate (
      .key({src_region[s], src_addr[s][29:16]}),
      .low_addr(src_addr[s][29:0]),
      .base_low(xlate_base_low[src_region[s]]),
      .limit(xlate_limit[src_region[s]]),
      .tgt_high(xlate_target_high[src_region[s]]),
      .tgt_low(xlate_target_low[src_region[s]]),
      .enable(xlate_region_enable[src_region[s]]),
      .hit(src_hit[s]),
      .pcie_addr(src_pcie[s])
    );
  end

  logic sb_take;
  logic fd_take;
  logic ob_free;
  logic [10:0] hdr;

  // Only accesses inside the top gigabyte are taken; ack guards re-acceptance
  assign ob_free = endpoint_ready && (!ob_valid || ob_ready);
  assign sb_take = ob_free && sb_req && !sb_ack && (sb_addr[31:30] == `POX_WIN_TAG);
  assign fd_take = ob_free && !sb_take && fd_req && !fd_ack &&
                   (fd_addr[31:30] == `POX_WIN_TAG);
  assign hdr = xlate_header_config[fd_take ? framedma_region_select : sysbus_region_select];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_ack <= 1'b0;
      fd_ack <= 1'b0;
      ob_valid <= 1'b0;
      ob_write <= 1'b0;
      ob_src <= POX_SRC_SYSBUS;
      ob_translated <= 1'b0;
      ob_addr <= 64'h0;
      ob_attr <= 2'h0;
      ob_td <= 1'b0;
      ob_tc <= 3'h0;
      ob_type <= 5'h00;
      ob_poison <= 1'b0;
      ob_be <= 4'h0;
      ob_msg_code <= 8'h00;
    end else if (pclken) begin
      sb_ack <= sb_take;
      fd_ack <= fd_take;
      if (sb_take || fd_take) begin
        ob_valid <= 1'b1;
        ob_write <= fd_take ? fd_write : sb_write;
        ob_src <= fd_take ? POX_SRC_FRAMEDMA : POX_SRC_SYSBUS;
        // Untranslated accesses keep the plain 30-bit offset
        ob_translated <= src_hit[fd_take];
        ob_addr <= src_hit[fd_take] ? src_pcie[fd_take] : {34'h0, src_addr[fd_take][29:0]};
        ob_attr <= hdr[`POX_HDR_ATTR_LSB +: 2];
        ob_td <= hdr[`POX_HDR_TD_BIT];
        ob_tc <= hdr[`POX_HDR_TC_LSB +: 3];
        ob_type <= hdr[`POX_HDR_TYPE_LSB +: 5];
        ob_msg_code <= tlp_message_code[fd_take ? framedma_region_select
                                                : sysbus_region_select];
        ob_poison <= fd_take ? 1'b0 : sysbus_poison_flag;
        ob_be <= fd_take ? `POX_RST_FD_BE : sysbus_byte_enables;
      end else if (ob_ready) begin
        ob_valid <= 1'b0;
      end
    end
  end
endmodule : pox_outbound
`default_nettype wire

// >>> pox_outbound_sva.sv
// Checker for the outbound block: requests, translation and message handshakes.
// Bound to pox_outbound; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module pox_outbound_sva import pox_pkg::*; #(
  parameter int VEC_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic msi_cap_enable,
  input wire logic endpoint_ready,
  input wire logic msg_valid,
  input wire pox_msg_t msg_type,
  input wire logic [VEC_W-1:0] msg_vector,
  input wire logic msg_ready,
  input wire logic [2:0] msg_tc,
  input wire logic sb_req,
  input wire logic sb_write,
  input wire logic [31:0] sb_addr,
  input wire logic sb_ack,
  input wire logic fd_req,
  input wire logic [31:0] fd_addr,
  input wire logic fd_ack,
  input wire logic ob_valid,
  input wire logic ob_write,
  input wire pox_src_t ob_src,
  input wire logic ob_translated,
  input wire logic [63:0] ob_addr,
  input wire logic ob_poison,
  input wire logic [3:0] ob_be,
  input wire logic ob_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence sb_take_s;
    sb_req && sb_addr[31:30] == 2'h3 && endpoint_ready && !sb_ack && (!ob_valid || ob_ready);
  endsequence
  // Narrower than the design's rule: only checked when no system bus request competes
  sequence fd_take_s;
    fd_req && !sb_req && fd_addr[31:30] == 2'h3 && endpoint_ready && !fd_ack
      && (!ob_valid || ob_ready);
  endsequence
  property msi_mode_p;
    $rose(msg_valid) && msg_type == POX_MSG_MSI |-> $past(msi_cap_enable);
  endproperty
  sb_take_a: assert property (sb_take_s |=> sb_ack && ob_write == $past(sb_write))
    else $error("system bus request not answered");
  fd_take_a: assert property (fd_take_s |=> fd_ack && ob_src == POX_SRC_FRAMEDMA)
    else $error("frame dma request not answered");
  fd_hdr_a: assert property (fd_ack |-> !ob_poison && ob_be == 4'hf)
    else $error("frame dma header wrong");
  low_bits_a: assert property (sb_ack |-> ob_addr[15:0] == $past(sb_addr[15:0]))
    else $error("low address bits altered");
  window_a: assert property (ob_valid && !ob_translated |-> ob_addr[63:30] == '0)
    else $error("untranslated address leaves window");
  idle_ep_a: assert property (sb_req && !endpoint_ready |=> !sb_ack)
    else $error("request answered before endpoint ready");
  ack_pulse_a: assert property (sb_ack |=> !sb_ack)
    else $error("acknowledge longer than one cycle");
  ob_hold_a: assert property (ob_valid && !ob_ready |=> ob_valid && $stable(ob_addr))
    else $error("outbound request dropped while stalled");
  msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_vector))
    else $error("message changed while stalled");
  legacy_msg_a: assert property (msg_valid && msg_type != POX_MSG_MSI |-> msg_tc == 3'h0)
    else $error("legacy message carries a class");
  msi_mode_a: assert property (msi_mode_p)
    else $error("message sent outside message mode");
endmodule : pox_outbound_sva
bind pox_outbound pox_outbound_sva #(.VEC_W(VEC_W)) u_sva (.*);
`default_nettype wire

// >>> pox_host_model.sv
// Root complex stand-in: takes interrupt messages and outbound requests.
// Assumes the design holds valid until ready; slow stalls every other cycle.
`timescale 1ns/10ps
`default_nettype none
module pox_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic msg_valid,
  input wire logic ob_valid,
  output logic msg_ready,
  output logic ob_ready,
  output var int msg_count,
  output var int ob_count
);
  logic phase;
  // Opposite phases so each path meets its own stall pattern
  assign msg_ready = !slow || phase;
  assign ob_ready = !slow || !phase;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 1'b0;
      msg_count <= 0;
      ob_count <= 0;
    end else begin
      phase <= !phase;
      if (msg_valid && msg_ready) msg_count <= msg_count + 1;
      if (ob_valid && ob_ready) ob_count <= ob_count + 1;
    end
  end
endmodule : pox_host_model
`default_nettype wire

// >>> pox_outbound_tb.sv
// Self-checking bench: APB tasks, request tasks and a host model on the far side.
// Assumes one 20 MHz clock; everything is synchronous to it.
`timescale 1ns/10ps
`default_nettype none
module pox_outbound_tb import pox_pkg::*;;
  logic pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, sb_addr, fd_addr;
  logic msi_cap_enable, endpoint_ready, irq_destination_zero, irq_destination_one;
  logic msg_valid, msg_ready, sb_req, sb_write, sb_ack, fd_req, fd_write, fd_ack, slow;
  logic ob_valid, ob_write, ob_translated, ob_td, ob_poison, ob_ready;
  pox_msg_t msg_type;
  pox_src_t ob_src;
  logic [7:0] msg_vector, ob_msg_code;
  logic [2:0] msg_tc, ob_tc;
  logic [63:0] ob_addr;
  logic [1:0] ob_attr;
  logic [4:0] ob_type;
  logic [3:0] ob_be;
  int msg_count, ob_count, miscompares, total_checks, base;
  int cycles = 0;

  pox_outbound dut (.*);
  pox_host_model host (.*);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Whole run needs well under this
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Read data taken at the very edge that samples pready, then released
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1'b1);
  endtask : rw

  task irq(input logic z, input logic o);
    @(posedge pclk);
    irq_destination_zero <= z;
    irq_destination_one <= o;
  endtask : irq

  task wmsg(input pox_msg_t t, input logic [7:0] v, input logic [2:0] c);
    int n;
    n = 0;
    while (msg_valid !== 1'b1 && n < 40) begin @(negedge pclk); n++; end
    chk(msg_valid, 1'b1);
    chk(msg_type, t);
    chk(msg_vector, v);
    chk(msg_tc, c);
    while (msg_valid === 1'b1 && n < 80) begin @(negedge pclk); n++; end
  endtask : wmsg

  // Returns at the edge that samples the acknowledge; caller sees the fresh request
  task req(input logic s, input logic w, input logic [31:0] a);
    int n;
    n = 0;
    @(posedge pclk);
    if (s) begin fd_req <= 1'b1; fd_write <= w; fd_addr <= a; end
    else begin sb_req <= 1'b1; sb_write <= w; sb_addr <= a; end
    do begin @(posedge pclk); n++; end while ((s ? fd_ack : sb_ack) !== 1'b1 && n < 30);
    sb_req <= 1'b0;
    fd_req <= 1'b0;
    chk(n < 30, 1'b1);
  endtask : req

  initial begin
    {psel, penable, pwrite, paddr, pwdata, sb_req, sb_write, sb_addr} = '0;
    {fd_req, fd_write, fd_addr, irq_destination_zero, irq_destination_one} = '0;
    {msi_cap_enable, endpoint_ready, slow, presetn} = '0;
    pclken = 1'b1;
    miscompares = 0;
    total_checks = 0;
    cyc(6);
    presetn <= 1'b1;
    rw(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'hf0);
    rw(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h0);
    rw(1'b1, 12'h040, 32'hffffffff);
    chk(pslverr, 1'b1);
    $display("register test done");
    rw(1'b1, 12'h000, 32'h3);
    base = msg_count;
    irq(1'b1, 1'b0);
    cyc(8);
    chk(msg_count, base);
    // Clock enable low must freeze the message path
    pclken <= 1'b0;
    irq(1'b1, 1'b1);
    cyc(4);
    chk(msg_valid, 1'b0);
    pclken <= 1'b1;
    wmsg(POX_MSG_ASSERT_INTA, 8'h0, 3'h0);
    irq(1'b1, 1'b0);
    wmsg(POX_MSG_DEASSERT_INTA, 8'h0, 3'h0);
    irq(1'b0, 1'b0);
    rw(1'b1, 12'h000, 32'h0);
    msi_cap_enable <= 1'b1;
    rw(1'b1, 12'h004, 32'h03221101);
    rw(1'b1, 12'h008, 32'h05443302);
    base = msg_count;
    irq(1'b1, 1'b1);
    cyc(4);
    irq(1'b0, 1'b0);
    cyc(8);
    chk(msg_count, base);
    rw(1'b1, 12'h000, 32'h1);
    slow <= 1'b1;
    irq(1'b1, 1'b0);
    wmsg(POX_MSG_MSI, 8'h11, 3'h3);
    irq(1'b0, 1'b1);
    cyc(8);
    chk(msg_count, base + 1);
    irq(1'b0, 1'b0);
    wmsg(POX_MSG_MSI, 8'h44, 3'h5);
    $display("interrupt test done");
    rw(1'b1, 12'h00c, 32'h52);
    rw(1'b1, 12'h014, 32'h0);
    rw(1'b1, 12'h018, 32'h0);
    rw(1'b1, 12'h01c, 32'h3fff);
    rw(1'b1, 12'h020, 32'h240);
    rw(1'b1, 12'h028, 32'h1000);
    rw(1'b1, 12'h02c, 32'h1);
    sb_req <= 1'b1;
    sb_addr <= 32'hc0001234;
    cyc(6);
    chk(ob_count, 0);
    endpoint_ready <= 1'b1;
    req(1'b0, 1'b0, 32'hc0001234);
    chk(ob_translated, 1'b0);
    chk(ob_addr, 64'h1234);
    rw(1'b1, 12'h024, 32'h80000007);
    req(1'b0, 1'b1, 32'hc0001234);
    chk(ob_addr, 64'h110001234);
    chk({ob_translated, ob_write, ob_poison, ob_be}, 7'b1110101);
    chk({ob_attr, ob_td, ob_tc, ob_type, ob_msg_code}, {2'h1, 1'b0, 3'h2, 5'h0, 8'h07});
    rw(1'b1, 12'h010, 32'h1);
    rw(1'b1, 12'h014, 32'h1);
    rw(1'b1, 12'h018, 32'h4000);
    rw(1'b1, 12'h01c, 32'h7fff);
    rw(1'b1, 12'h020, 32'h460);
    rw(1'b1, 12'h028, 32'h2000);
    rw(1'b1, 12'h02c, 32'h0);
    rw(1'b1, 12'h024, 32'h80000000);
    rw(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h4000);
    rw(1'b1, 12'h014, 32'h0);
    rw(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    req(1'b1, 1'b0, 32'hc0005678);
    chk(ob_src, POX_SRC_FRAMEDMA);
    chk(ob_addr, 64'h20005678);
    chk({ob_attr, ob_tc, ob_poison, ob_be}, {2'h2, 3'h3, 1'b0, 4'hf});
    cyc(2);
    chk(ob_count, 3);
    rw(1'b0, 12'h030, 32'h0);
    chk(rd, 32'h18);
    $display("translation test done");
    complete_run();
  end
endmodule : pox_outbound_tb
`default_nettype wire
